// ==== shared/flash_prot_pkg.sv ====
// Operation
// - main store 64 pages; info pages 2048 bytes
// - erase whole pages, program aligned half-words
// - main store at 0 only in normal boot
// - factory page 0x08040000, aliased at 0 in monitor
// - user page 0x08040800, never fetched
// - option word: data low, hardware inverse high
// - first eight user half-words are options 0-7
// - inverse mismatch at reset flags error, halts processor
// - options 4,5 bits guard sixteen 4-page regions
// - cleared write-protect bit protects; 0xFF none
// - write-protect changes apply after next reset
// - protected region blocks program and page erase
// - read protection off only when option 0 0xA5
// - read-protect state changes only at chip reset
// - debugger sets intrusion latch; pin reset clears
// - protection plus intrusion disconnects all flash
// - erasing option 0 under protection mass-erases main
// - read protection write-protects lowest four pages
// - options 2,3 checked and shadowed, drive nothing else
package flash_prot_pkg;

    localparam int unsigned PAGE_BYTES = 2048;
    localparam int unsigned MAIN_PAGES = 64;
    localparam int unsigned REGION_PAGES = 4;
    localparam int unsigned REGIONS = 16;
    localparam int unsigned OPT_COUNT = 8;
    localparam int unsigned OPT_IDX_W = 3;
    localparam int unsigned MAIN_OFF_W = 17;
    localparam int unsigned REGION_SHIFT = 13;

    localparam logic [31:0] MAIN_BYTES = 32'(MAIN_PAGES * PAGE_BYTES);
    localparam logic [31:0] PAGE_SIZE = 32'(PAGE_BYTES);
    localparam logic [31:0] OPT_AREA_BYTES = 32'(OPT_COUNT * 2);

    localparam logic [31:0] MAIN_BASE = 32'h0800_0000;
    localparam logic [31:0] BOOT_ALIAS_BASE = 32'h0000_0000;
    localparam logic [31:0] FACTORY_BASE = 32'h0804_0000;
    localparam logic [31:0] USER_BASE = 32'h0804_0800;

    // option words, as flash half-word addresses
    localparam logic [31:0] READ_PROTECT_OPTION = 32'h0804_0800;
    localparam logic [31:0] VENDOR_RESERVED_OPTION_A = 32'h0804_0802;
    localparam logic [31:0] CUSTOMER_OPTION_A = 32'h0804_0804;
    localparam logic [31:0] CUSTOMER_OPTION_B = 32'h0804_0806;
    localparam logic [31:0] WRITE_PROTECT_LOW_REGIONS = 32'h0804_0808;
    localparam logic [31:0] WRITE_PROTECT_HIGH_REGIONS = 32'h0804_080a;
    localparam logic [31:0] VENDOR_RESERVED_OPTION_B = 32'h0804_080c;
    localparam logic [31:0] VENDOR_RESERVED_OPTION_C = 32'h0804_080e;

    localparam logic [OPT_IDX_W-1:0] OPT_RP_IDX = 3'h0;
    localparam logic [OPT_IDX_W-1:0] OPT_WP_LOW_IDX = 3'h4;
    localparam logic [OPT_IDX_W-1:0] OPT_WP_HIGH_IDX = 3'h5;
    localparam logic [OPT_IDX_W-1:0] OPT_LAST_IDX = 3'h7;

    localparam logic [7:0] RP_DISABLE_CODE = 8'ha5;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // safe values until the option load completes
    localparam logic RP_RESET = 1'b1;
    localparam logic INTRUSION_RESET = 1'b1;
    localparam logic [REGIONS-1:0] WP_RESET = 16'h0000;

    typedef enum logic [1:0] {OP_READ, OP_FETCH, OP_PROGRAM, OP_ERASE} op_t;
    typedef enum logic [1:0] {BLK_NONE, BLK_MAIN, BLK_FACTORY, BLK_USER} blk_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic [31:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic valid;
        blk_t blk;
        op_t op;
        logic [MAIN_OFF_W-1:0] offset;
        logic [15:0] wdata;
        logic mass_erase;
    } flash_cmd_t;

endpackage : flash_prot_pkg

// ==== rtl/option_shadow_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_shadow_mem #(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned WIDTH = 16,
    parameter int unsigned IDX_W = 3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // write port
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data_q
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem[rd_idx];
        end
    end

endmodule : option_shadow_mem
`default_nettype wire

// ==== rtl/flash_option_byte_protection.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_option_byte_protection
    import flash_prot_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // reset cause and boot straps, valid after release
    input wire logic pin_reset_cause,
    input wire logic factory_monitor_boot,
    input wire logic debug_connected,
    // bus master request and answer
    input wire bus_req_t req,
    output logic rsp_valid_q,
    output logic rsp_error_q,
    // command to the flash array
    output flash_cmd_t cmd_q,
    // option word fetch from the user page
    output logic ob_rd_req_q,
    output logic [OPT_IDX_W-1:0] ob_rd_idx_q,
    input wire logic ob_rd_valid,
    input wire logic [15:0] ob_rd_data,
    // shadow readback
    input wire logic [OPT_IDX_W-1:0] shadow_rd_idx,
    output logic [15:0] shadow_rd_data_q,
    // status
    output logic cpu_hold_q,
    output logic option_error_q,
    output logic read_protect_q,
    output logic intrusion_q,
    output logic flash_off_bus_q,
    output logic [REGIONS-1:0] region_locked_q
);

    typedef enum logic [2:0] {LD_START, LD_ISSUE, LD_WAIT, LD_DONE, LD_FAULT} load_state_t;

    load_state_t state_q, state_d;
    logic monitor_q;
    logic ready_q;
    logic mismatch_q;
    logic [7:0] wp_low_q, wp_high_q;
    logic [REGIONS-1:0] wp_q;

    // ------------------------------------------------------------------
    // option loader
    // ------------------------------------------------------------------
    wire logic word_ok = (ob_rd_data[15:8] == ~ob_rd_data[7:0]);
    wire logic load_word = (state_q == LD_WAIT) && ob_rd_valid;
    wire logic last_word = (ob_rd_idx_q == OPT_LAST_IDX);
    wire logic any_bad = mismatch_q || !word_ok;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LD_START: state_d = LD_ISSUE;
            LD_ISSUE: state_d = LD_WAIT;
            LD_WAIT: begin
                if (load_word) begin
                    if (!last_word) begin
                        state_d = LD_ISSUE;
                    end else if (any_bad) begin
                        state_d = LD_FAULT;
                    end else begin
                        state_d = LD_DONE;
                    end
                end
            end
            LD_DONE: state_d = LD_DONE;
            LD_FAULT: state_d = LD_FAULT;
            default: state_d = LD_FAULT;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= LD_START;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ob_rd_req_q <= 1'b0;
            ob_rd_idx_q <= '0;
            mismatch_q <= 1'b0;
        end else begin
            ob_rd_req_q <= (state_q == LD_ISSUE);
            if (load_word) begin
                mismatch_q <= any_bad;
                if (!last_word) begin
                    ob_rd_idx_q <= ob_rd_idx_q + 3'h1;
                end
            end
        end
    end

    // every word lands in the shadow, options 2 and 3 go nowhere else
    option_shadow_mem #(
        .DEPTH(OPT_COUNT),
        .WIDTH(16),
        .IDX_W(OPT_IDX_W)
    ) u_shadow (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(load_word),
        .wr_idx(ob_rd_idx_q),
        .wr_data(ob_rd_data),
        .rd_idx(shadow_rd_idx),
        .rd_data_q(shadow_rd_data_q)
    );

    // protection state is only captured while loading, never later
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            read_protect_q <= RP_RESET;
            wp_low_q <= 8'h00;
            wp_high_q <= 8'h00;
        end else if (load_word) begin
            if (ob_rd_idx_q == OPT_RP_IDX) begin
                read_protect_q <= (ob_rd_data[7:0] != RP_DISABLE_CODE);
            end
            if (ob_rd_idx_q == OPT_WP_LOW_IDX) begin
                wp_low_q <= ob_rd_data[7:0];
            end
            if (ob_rd_idx_q == OPT_WP_HIGH_IDX) begin
                wp_high_q <= ob_rd_data[7:0];
            end
        end
    end

    // a bit pattern from a load that failed its check is not trusted
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wp_q <= WP_RESET;
        end else if (state_q == LD_DONE) begin
            wp_q <= {wp_high_q, wp_low_q};
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            monitor_q <= 1'b0;
            ready_q <= 1'b0;
            cpu_hold_q <= 1'b1;
            option_error_q <= 1'b0;
        end else begin
            if (state_q == LD_START) begin
                monitor_q <= factory_monitor_boot;
            end
            ready_q <= (state_q == LD_DONE);
            cpu_hold_q <= (state_q != LD_DONE);
            option_error_q <= (state_q == LD_FAULT);
        end
    end

    // ------------------------------------------------------------------
    // intrusion latch
    // ------------------------------------------------------------------
    // starts set so a chip reset alone cannot drop it; only a pin reset
    // with no debugger attached clears it, and a connect always wins
    wire logic intrusion_clear = (state_q == LD_START) && pin_reset_cause && !debug_connected;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            intrusion_q <= INTRUSION_RESET;
        end else if (debug_connected) begin
            intrusion_q <= 1'b1;
        end else if (intrusion_clear) begin
            intrusion_q <= 1'b0;
        end
    end

    wire logic off_bus = read_protect_q && intrusion_q;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire logic [31:0] main_hi_off = req.addr - MAIN_BASE;
    wire logic [31:0] alias_off = req.addr - BOOT_ALIAS_BASE;
    wire logic [31:0] fact_off = req.addr - FACTORY_BASE;
    wire logic [31:0] user_off = req.addr - USER_BASE;

    wire logic hit_main_hi = main_hi_off < MAIN_BYTES;
    wire logic hit_main_lo = !monitor_q && (alias_off < MAIN_BYTES);
    wire logic hit_fact_hi = fact_off < PAGE_SIZE;
    wire logic hit_fact_lo = monitor_q && (alias_off < PAGE_SIZE);
    wire logic hit_user = user_off < PAGE_SIZE;

    wire logic in_main = hit_main_hi || hit_main_lo;
    wire logic in_fact = hit_fact_hi || hit_fact_lo;

    wire logic [31:0] sel_off = hit_main_hi ? main_hi_off :
                                (hit_main_lo || hit_fact_lo) ? alias_off :
                                hit_fact_hi ? fact_off : user_off;
    wire logic [MAIN_OFF_W-1:0] blk_off = sel_off[MAIN_OFF_W-1:0];

    wire blk_t blk = in_main ? BLK_MAIN : in_fact ? BLK_FACTORY : hit_user ? BLK_USER : BLK_NONE;

    // ------------------------------------------------------------------
    // access checks
    // ------------------------------------------------------------------
    wire logic is_prog = (req.op == OP_PROGRAM);
    wire logic is_erase = (req.op == OP_ERASE);
    wire logic is_fetch = (req.op == OP_FETCH);
    wire logic modifies = is_prog || is_erase;

    wire logic [3:0] region = blk_off[REGION_SHIFT +: 4];

    // cleared option bit protects; bottom region also locked by read protection
    wire logic [REGIONS-1:0] locked = ~wp_q | {{(REGIONS-1){1'b0}}, read_protect_q};
    wire logic region_locked = locked[region];

    wire logic err_unmapped = (blk == BLK_NONE);
    wire logic err_fetch = is_fetch && (blk == BLK_USER);
    wire logic err_align = is_prog && blk_off[0];
    wire logic err_factory = modifies && (blk == BLK_FACTORY);
    wire logic err_wp = modifies && (blk == BLK_MAIN) && region_locked;

    wire logic err_any = !ready_q || off_bus || err_unmapped || err_fetch
                         || err_align || err_factory || err_wp;

    // erase acts on the page holding the address
    wire logic [MAIN_OFF_W-1:0] page_mask = ~MAIN_OFF_W'(PAGE_BYTES - 1);
    wire logic [MAIN_OFF_W-1:0] cmd_off = is_erase ? (blk_off & page_mask) : blk_off;

    // option words get their inverse from hardware; user bits above are dropped
    wire logic opt_word = (blk == BLK_USER) && (user_off < OPT_AREA_BYTES);
    wire logic [15:0] cmd_wdata = opt_word ? {~req.wdata[7:0], req.wdata[7:0]} : req.wdata;

    // the only way to erase option 0 is a user page erase; under read
    // protection it also wipes the main store so no readout survives
    wire logic mass_erase = is_erase && (blk == BLK_USER) && read_protect_q;

    wire logic accept = req.valid && !err_any;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rsp_valid_q <= 1'b0;
            rsp_error_q <= 1'b0;
        end else begin
            rsp_valid_q <= req.valid;
            rsp_error_q <= req.valid && err_any;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmd_q <= '0;
        end else begin
            cmd_q.valid <= accept;
            cmd_q.blk <= accept ? blk : BLK_NONE;
            cmd_q.op <= req.op;
            cmd_q.offset <= cmd_off;
            cmd_q.wdata <= cmd_wdata;
            cmd_q.mass_erase <= accept && mass_erase;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flash_off_bus_q <= 1'b1;
            region_locked_q <= '1;
        end else begin
            flash_off_bus_q <= off_bus;
            region_locked_q <= locked;
        end
    end

endmodule : flash_option_byte_protection
`default_nettype wire

// ==== verif/fob_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fob_sva
    import flash_prot_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // strap and bus
    input wire logic factory_monitor_boot,
    input wire bus_req_t req,
    input wire logic rsp_error_q,
    input wire flash_cmd_t cmd_q,
    // status
    input wire logic cpu_hold_q,
    input wire logic read_protect_q,
    input wire logic intrusion_q,
    input wire logic [REGIONS-1:0] region_locked_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    wire logic wr_op = req.valid && (req.op == OP_PROGRAM || req.op == OP_ERASE);
    wire logic off_bus = read_protect_q && intrusion_q;
    property p_held; req.valid && cpu_hold_q |=> rsp_error_q && !cmd_q.valid; endproperty
    a_held: assert property (p_held) else $error("request taken while held");
    property p_odd; req.valid && req.op == OP_PROGRAM && req.addr[0] |=> rsp_error_q; endproperty
    a_odd: assert property (p_odd) else $error("odd program taken");
    property p_inv; cmd_q.valid && cmd_q.blk == BLK_USER && cmd_q.op == OP_PROGRAM && cmd_q.offset < 17'h0_0010
        |-> cmd_q.wdata[15:8] == ~cmd_q.wdata[7:0]; endproperty
    a_inv: assert property (p_inv) else $error("option inverse wrong");
    // locks are only trusted two cycles after release of the hold
    property p_lock; !$past(cpu_hold_q, 2) && wr_op && req.addr[31:17] == MAIN_BASE[31:17]
        && region_locked_q[req.addr[16:13]] |=> rsp_error_q; endproperty
    a_lock: assert property (p_lock) else $error("locked region written");
    property p_low; wr_op && read_protect_q && req.addr[31:13] == MAIN_BASE[31:13] |=> rsp_error_q; endproperty
    a_low: assert property (p_low) else $error("low pages written under protection");
    property p_frozen; !cpu_hold_q && !$past(cpu_hold_q, 2) |-> $stable(read_protect_q); endproperty
    a_frozen: assert property (p_frozen) else $error("read protection changed");
    property p_off; req.valid && off_bus |=> rsp_error_q && !cmd_q.valid; endproperty
    a_off: assert property (p_off) else $error("access while off bus");
    property p_alias; req.valid && req.op == OP_READ && req.addr[31:11] == 21'h00_0000 && !cpu_hold_q && !off_bus
        |=> cmd_q.blk == (factory_monitor_boot ? BLK_FACTORY : BLK_MAIN); endproperty
    a_alias: assert property (p_alias) else $error("boot alias wrong");
    c_mass: cover property (cmd_q.valid && cmd_q.mass_erase);
    c_off: cover property (req.valid && off_bus);
    c_lock: cover property (wr_op && region_locked_q[req.addr[16:13]] && !cpu_hold_q);
endmodule : fob_sva
`default_nettype wire

// ==== verif/option_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_flash_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // option word port
    input wire logic rd_req,
    input wire logic [2:0] rd_idx,
    output logic rd_valid,
    output logic [15:0] rd_data,
    // contents and answer speed
    input wire logic [127:0] words,
    input wire logic slow
);
    logic [3:0] wait_q;
    logic [2:0] idx_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wait_q <= 4'h0;
            idx_q <= 3'h0;
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= (wait_q == 4'h1);
            // data toggles when idle so a stale word is never mistaken for an answer
            rd_data <= (wait_q == 4'h1) ? words[idx_q*16 +: 16] : ~rd_data;
            if (rd_req) begin
                wait_q <= slow ? 4'h6 : 4'h1;
                idx_q <= rd_idx;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule : option_flash_model
`default_nettype wire

// ==== verif/flash_option_byte_protection_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
bind flash_option_byte_protection fob_sva chk_u (.sys_clk(sys_clk), .reset(reset),
    .factory_monitor_boot(factory_monitor_boot), .req(req), .rsp_error_q(rsp_error_q), .cmd_q(cmd_q),
    .cpu_hold_q(cpu_hold_q), .read_protect_q(read_protect_q), .intrusion_q(intrusion_q),
    .region_locked_q(region_locked_q));
module flash_option_byte_protection_tb_top
    import flash_prot_pkg::*;
;
    // note: refused, mass erase, check wdata, block, offset, wdata
    localparam logic [37:0] NO = 38'h20_0000_0000;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic pin_reset_cause = 1'b1;
    logic factory_monitor_boot = 1'b0;
    logic debug_connected = 1'b0;
    logic slow = 1'b0;
    logic [127:0] words = '1;
    logic [2:0] shadow_rd_idx = 3'h0;
    bus_req_t req = '0;
    logic rsp_valid_q, rsp_error_q, ob_rd_req_q, ob_rd_valid, cpu_hold_q, option_error_q;
    logic read_protect_q, intrusion_q, flash_off_bus_q;
    logic [2:0] ob_rd_idx_q;
    logic [15:0] ob_rd_data, shadow_rd_data_q, d, wp;
    logic [REGIONS-1:0] region_locked_q;
    logic [7:0] c2;
    flash_cmd_t cmd_q;
    logic [37:0] notes[$];
    logic [37:0] nt;
    logic [31:0] ra;
    logic [16:0] ro;
    int num_errors = 0;
    int checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    flash_option_byte_protection dut_u (.sys_clk(sys_clk), .reset(reset), .pin_reset_cause(pin_reset_cause),
        .factory_monitor_boot(factory_monitor_boot), .debug_connected(debug_connected), .req(req),
        .rsp_valid_q(rsp_valid_q), .rsp_error_q(rsp_error_q), .cmd_q(cmd_q), .ob_rd_req_q(ob_rd_req_q),
        .ob_rd_idx_q(ob_rd_idx_q), .ob_rd_valid(ob_rd_valid), .ob_rd_data(ob_rd_data),
        .shadow_rd_idx(shadow_rd_idx), .shadow_rd_data_q(shadow_rd_data_q), .cpu_hold_q(cpu_hold_q),
        .option_error_q(option_error_q), .read_protect_q(read_protect_q), .intrusion_q(intrusion_q),
        .flash_off_bus_q(flash_off_bus_q), .region_locked_q(region_locked_q));
    option_flash_model flash_u (.sys_clk(sys_clk), .reset(reset), .rd_req(ob_rd_req_q), .rd_idx(ob_rd_idx_q),
        .rd_valid(ob_rd_valid), .rd_data(ob_rd_data), .words(words), .slow(slow));
    function automatic logic [15:0] ow(input logic [7:0] b);
        return {~b, b};
    endfunction : ow
    function automatic logic [127:0] opts(input logic [7:0] rp, input logic [7:0] lo, input logic [7:0] hi);
        return {ow(8'hff), ow(8'hff), ow(hi), ow(lo), ow(c2), ow(c2), ow(8'hff), ow(rp)};
    endfunction : opts
    function automatic logic [37:0] ok(input blk_t b, input logic m, input logic cw, input logic [16:0] o,
        input logic [15:0] w);
        return {1'b0, m, cw, b, o, w};
    endfunction : ok
    task automatic report_and_stop;
        `CHK("pending notes", 0, notes.size())
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic boot(input logic [127:0] w, input logic pin, input logic mon, input logic sl);
        int n;
        words <= w;
        pin_reset_cause <= pin;
        factory_monitor_boot <= mon;
        slow <= sl;
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        n = 0;
        @(posedge sys_clk);
        while (cpu_hold_q === 1'b1 && option_error_q !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            report_and_stop;
        end
        repeat (3) @(posedge sys_clk);
    endtask : boot
    // request stays up so callers may issue back to back; idle drops it
    task automatic access(input op_t op, input logic [31:0] a, input logic [15:0] w, input logic [37:0] n);
        req <= '{valid: 1'b1, op: op, addr: a, wdata: w};
        notes.push_back(n);
        @(posedge sys_clk);
    endtask : access
    task automatic idle;
        req.valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : idle
    always @(negedge sys_clk) begin
        if (rsp_valid_q === 1'b1) begin
            nt = (notes.size() > 0) ? notes.pop_front() : ~NO;
            `CHK("refusal", {nt[37], ~nt[37]}, {rsp_error_q, cmd_q.valid})
            if (nt[37] == 1'b0) `CHK("block", {nt[36], nt[34:33]}, {cmd_q.mass_erase, cmd_q.blk})
            if (nt[37] == 1'b0) `CHK("offset", nt[32:16], cmd_q.offset)
            if (nt[35] == 1'b1) `CHK("wdata", nt[15:0], cmd_q.wdata)
        end
    end
    initial begin
        void'($urandom(40807));
        wp = 16'($urandom());
        c2 = 8'($urandom());
        @(posedge sys_clk);
        boot(opts(8'ha5, wp[7:0], wp[15:8]), 1'b1, 1'b0, 1'b0);
        `CHK("read_protect", 1'b0, read_protect_q)
        `CHK("intrusion", 1'b0, intrusion_q)
        `CHK("locks", ~wp, region_locked_q)
        shadow_rd_idx <= 3'h2;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("shadow", ow(c2), shadow_rd_data_q)
        @(posedge sys_clk);
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom());
            ro = 17'(i * 32'h0000_2000);
            ra = MAIN_BASE + 32'(ro);
            access(OP_PROGRAM, ra + 32'h0000_0002, d, wp[i] ? ok(BLK_MAIN, 1'b0, 1'b1, ro + 17'h0_0002, d) : NO);
            // erase address sits mid-page so the page alignment shows
            access(OP_ERASE, ra + PAGE_SIZE + 32'h0000_0010, 16'h0000,
                wp[i] ? ok(BLK_MAIN, 1'b0, 1'b0, ro + 17'h0_0800, 16'h0000) : NO);
        end
        access(OP_READ, 32'h0000_0010, 16'h0000, ok(BLK_MAIN, 1'b0, 1'b0, 17'h0_0010, 16'h0000));
        access(OP_READ, FACTORY_BASE + 32'h0000_0020, 16'h0000, ok(BLK_FACTORY, 1'b0, 1'b0, 17'h0_0020, 16'h0000));
        access(OP_FETCH, USER_BASE + 32'h0000_0010, 16'h0000, NO);
        access(OP_PROGRAM, MAIN_BASE + 32'h0000_4003, d, NO);
        access(OP_PROGRAM, CUSTOMER_OPTION_A, d, ok(BLK_USER, 1'b0, 1'b1, 17'h0_0004, ow(d[7:0])));
        access(OP_ERASE, USER_BASE + 32'h0000_0022, 16'h0000, ok(BLK_USER, 1'b0, 1'b0, 17'h0_0000, 16'h0000));
        access(OP_READ, 32'h1000_0000, 16'h0000, NO);
        idle;
        words <= '1;
        repeat (20) @(posedge sys_clk);
        `CHK("locks held", ~wp, region_locked_q)
        // read protection paired with a high-region lock, as software should
        boot(opts(8'hff, 8'hff, 8'h7f), 1'b1, 1'b1, 1'b1);
        `CHK("read_protect", 1'b1, read_protect_q)
        `CHK("locks", 16'h8001, region_locked_q)
        access(OP_READ, 32'h0000_0006, 16'h0000, ok(BLK_FACTORY, 1'b0, 1'b0, 17'h0_0006, 16'h0000));
        access(OP_PROGRAM, MAIN_BASE, d, NO);
        access(OP_PROGRAM, MAIN_BASE + 32'h0001_e000, d, NO);
        access(OP_PROGRAM, MAIN_BASE + 32'h0000_2000, d, ok(BLK_MAIN, 1'b0, 1'b1, 17'h0_2000, d));
        // option 0 is erased before its new value goes in
        access(OP_ERASE, USER_BASE, 16'h0000, ok(BLK_USER, 1'b1, 1'b0, 17'h0_0000, 16'h0000));
        access(OP_PROGRAM, READ_PROTECT_OPTION, 16'h12a5, ok(BLK_USER, 1'b0, 1'b1, 17'h0_0000, ow(8'ha5)));
        debug_connected <= 1'b1;
        idle;
        access(OP_READ, MAIN_BASE, 16'h0000, NO);
        idle;
        `CHK("intrusion", 1'b1, intrusion_q)
        `CHK("off bus", 1'b1, flash_off_bus_q)
        debug_connected <= 1'b0;
        boot(opts(8'ha5, 8'hff, 8'hff), 1'b0, 1'b0, 1'b0);
        `CHK("intrusion kept", 1'b1, intrusion_q)
        `CHK("off bus alone", 1'b0, flash_off_bus_q)
        boot(opts(8'ha5, 8'hff, 8'hff), 1'b1, 1'b0, 1'b1);
        `CHK("intrusion cleared", 1'b0, intrusion_q)
        boot(opts(8'ha5, 8'hff, 8'hff) ^ (128'h1 << 56), 1'b1, 1'b0, 1'b0);
        `CHK("fault", 2'b11, {option_error_q, cpu_hold_q})
        `CHK("fault locks", 16'hffff, region_locked_q)
        access(OP_READ, MAIN_BASE, 16'h0000, NO);
        idle;
        report_and_stop;
    end
endmodule : flash_option_byte_protection_tb_top
`default_nettype wire
